// File: rtl/dsf_pkg.sv
package dsf_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [6:0] DSF_DRIVER_STATUS_ADDR = 7'h6F;
   localparam int DSF_STST_BIT = 31;
   localparam int DSF_CS_HI = 20;
   localparam int DSF_CS_LO = 16;
   localparam int DSF_T_HIGH_BIT = 9;
   localparam int DSF_T_WARN_BIT = 8;
   localparam int DSF_OLB_BIT = 7;
   localparam int DSF_OLA_BIT = 6;
   localparam int DSF_LSB_BIT = 5;
   localparam int DSF_LSA_BIT = 4;
   localparam int DSF_GSB_BIT = 3;
   localparam int DSF_GSA_BIT = 2;
   localparam int DSF_OT_BIT = 1;
   localparam int DSF_OTPW_BIT = 0;
   localparam logic [31:0] DSF_STATUS_RESET = 32'h0000_0000;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int DSF_STST_CLOCKS = 1048576;
   localparam int DSF_STST_W = 21;
   localparam logic [DSF_STST_W-1:0] DSF_STST_ZERO = 21'h00_0000;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic temp_high_comparator;
      logic temp_warn_comparator;
      logic open_load_b;
      logic open_load_a;
      logic lowside_short_phase_b;
      logic lowside_short_phase_a;
      logic ground_short_phase_b;
      logic ground_short_phase_a;
      logic overtemp_limit;
   } dsf_detect_s;
   typedef struct packed {
      logic lowside_short_phase_b;
      logic lowside_short_phase_a;
      logic ground_short_phase_b;
      logic ground_short_phase_a;
   } dsf_shorts_s;
endpackage : dsf_pkg

// File: rtl/dsf_stst_timer.sv
`timescale 1ns/1ps
module dsf_stst_timer
   import dsf_pkg::*;
#(
   parameter int STST_CLOCKS = DSF_STST_CLOCKS
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic step_pulse,
   output logic standstill
);
   logic [DSF_STST_W-1:0] count;
   localparam logic [DSF_STST_W-1:0] LIMIT = DSF_STST_W'(STST_CLOCKS);

   // ------------------------------------------------------------
   // Count clocks since last step
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         count <= DSF_STST_ZERO;
         standstill <= 1'b0;
      end else if (ce) begin
         if (step_pulse) begin
            count <= DSF_STST_ZERO; // (RL2)
            standstill <= 1'b0; // (RL2)
         end else if (count != LIMIT) begin
            count <= count + 1'b1;
            standstill <= (count == LIMIT - 1'b1); // (RL2)
         end
      end
   end
endmodule : dsf_stst_timer

// File: rtl/dsf_driver_status.sv
// Overview of operation
// (RL1) The status word is readable by the host at register address 0x6F.
// (RL2) Bit 31 sets after 2^20 clocks without a step pulse and clears on the next step.
// (RL3) Bits 20..16 show the applied current scale.
// (RL4) Bit 9 follows the high temperature comparator and the drivers are off meanwhile.
// (RL5) Bit 8 follows the warning temperature comparator.
// (RL6) Bits 7 and 6 report open load on B and A and cause no driver action.
// (RL7) A low-side short sets bit 5 (B) or bit 4 (A) and disables the driver.
// (RL8) Low-side short flags are kept separately for each chopper mode; the code keeps the ground short flags per chopper mode as well.
// (RL9) A ground short sets bit 3 (B) or bit 2 (A) and disables the driver.
// (RL10) Short flags stay latched until the driver-on bit is 0 or the low-active enable is high.
// (RL11) Bit 1 sets at the overtemperature limit and holds the bridges off until bit 0 clears.
// (RL12) Bit 0 is one shared prewarning flag for both bridges.
// (RL13) Writes to the status register are ignored and reserved bits read zero.
`timescale 1ns/1ps
module dsf_driver_status
   import dsf_pkg::*;
#(
   parameter int STST_CLOCKS = DSF_STST_CLOCKS
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic step_pulse,
   input wire logic [4:0] current_scale,
   input wire logic chopper_mode,
   input wire dsf_detect_s detect,
   input wire logic driver_on,
   input wire logic enable_input_low_active_n,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [6:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_hit,
   output logic bridge_disable
);
   logic standstill;
   logic drv_active;
   dsf_shorts_s shorts_m0;
   dsf_shorts_s shorts_m1;
   dsf_shorts_s shorts_cur;
   logic [3:0] cur_bits;
   logic t_high;
   logic t_warn;
   logic open_b;
   logic open_a;
   logic ot_flag;
   logic otpw_flag;
   logic [4:0] cs_q;
   logic [31:0] status;
   logic thermal_off;
   logic short_off;
   logic rd_status;
   logic rd_other;

   // ------------------------------------------------------------
   // Standstill timer
   // ------------------------------------------------------------
   dsf_stst_timer #(.STST_CLOCKS(STST_CLOCKS)) u_stst (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .step_pulse(step_pulse),
      .standstill(standstill)
   );

   // ------------------------------------------------------------
   // Driver enable
   // ------------------------------------------------------------
   assign drv_active = driver_on & ~enable_input_low_active_n; // (RL10)

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   function automatic logic is_status_addr(input logic [6:0] addr);
      return addr == DSF_DRIVER_STATUS_ADDR;
   endfunction : is_status_addr

   // ------------------------------------------------------------
   // Short flag merge
   // ------------------------------------------------------------
   function automatic dsf_shorts_s merge_shorts(input dsf_shorts_s held,
      input dsf_detect_s det);
      dsf_shorts_s res;
      res.lowside_short_phase_b = held.lowside_short_phase_b | det.lowside_short_phase_b;
      res.lowside_short_phase_a = held.lowside_short_phase_a | det.lowside_short_phase_a;
      res.ground_short_phase_b = held.ground_short_phase_b | det.ground_short_phase_b;
      res.ground_short_phase_a = held.ground_short_phase_a | det.ground_short_phase_a;
      return res;
   endfunction : merge_shorts

   // ------------------------------------------------------------
   // Short latches, one set per chopper mode
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         shorts_m0 <= '0;
      end else if (ce) begin
         if (!drv_active) begin
            shorts_m0 <= '0; // (RL10)
         end else if (!chopper_mode) begin
            shorts_m0 <= merge_shorts(shorts_m0, detect); // (RL7) (RL8) (RL9)
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         shorts_m1 <= '0;
      end else if (ce) begin
         if (!drv_active) begin
            shorts_m1 <= '0; // (RL10)
         end else if (chopper_mode) begin
            shorts_m1 <= merge_shorts(shorts_m1, detect); // (RL7) (RL8) (RL9)
         end
      end
   end

   assign shorts_cur = chopper_mode ? shorts_m1 : shorts_m0; // (RL8)
   assign cur_bits = shorts_cur;

   // ------------------------------------------------------------
   // Thermal comparator samples
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         otpw_flag <= 1'b0;
         t_high <= 1'b0;
         t_warn <= 1'b0;
      end else if (ce) begin
         t_high <= detect.temp_high_comparator; // (RL4)
         t_warn <= detect.temp_warn_comparator; // (RL5)
         otpw_flag <= detect.temp_warn_comparator; // (RL12)
      end
   end

   // ------------------------------------------------------------
   // Overtemperature latch, held until prewarning clears
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         ot_flag <= 1'b0;
      end else if (ce) begin
         if (detect.overtemp_limit) begin
            ot_flag <= 1'b1; // (RL11)
         end else if (!detect.temp_warn_comparator) begin
            ot_flag <= 1'b0; // (RL11)
         end
      end
   end

   // ------------------------------------------------------------
   // Open load samples, informative only
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         open_b <= 1'b0;
         open_a <= 1'b0;
      end else if (ce) begin
         open_b <= detect.open_load_b; // (RL6)
         open_a <= detect.open_load_a; // (RL6)
      end
   end

   // ------------------------------------------------------------
   // Applied current scale sample
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         cs_q <= 5'h00;
      end else if (ce) begin
         cs_q <= current_scale; // (RL3)
      end
   end

   // ------------------------------------------------------------
   // Bridge disable; open load deliberately excluded
   // ------------------------------------------------------------
   assign thermal_off = ot_flag | t_high; // (RL4) (RL11)
   assign short_off = |cur_bits; // (RL7) (RL9)
   assign bridge_disable = thermal_off | short_off; // (RL6)

   // ------------------------------------------------------------
   // Status word assembly
   // ------------------------------------------------------------
   always_comb begin
      status = DSF_STATUS_RESET; // (RL13)
      status[DSF_STST_BIT] = standstill; // (RL2)
      status[DSF_CS_HI:DSF_CS_LO] = cs_q; // (RL3)
      status[DSF_T_HIGH_BIT] = t_high; // (RL4)
      status[DSF_T_WARN_BIT] = t_warn; // (RL5)
      status[DSF_OLB_BIT] = open_b; // (RL6)
      status[DSF_OLA_BIT] = open_a; // (RL6)
      status[DSF_LSB_BIT] = shorts_cur.lowside_short_phase_b; // (RL7)
      status[DSF_LSA_BIT] = shorts_cur.lowside_short_phase_a; // (RL7)
      status[DSF_GSB_BIT] = shorts_cur.ground_short_phase_b; // (RL9)
      status[DSF_GSA_BIT] = shorts_cur.ground_short_phase_a; // (RL9)
      status[DSF_OT_BIT] = ot_flag; // (RL11)
      status[DSF_OTPW_BIT] = otpw_flag; // (RL12)
   end

   // ------------------------------------------------------------
   // Register decode; writes have no effect
   // ------------------------------------------------------------
   assign reg_hit = (reg_rd | reg_wr) && is_status_addr(reg_addr); // (RL1)
   assign rd_status = reg_rd && is_status_addr(reg_addr); // (RL1)
   assign rd_other = reg_rd && !is_status_addr(reg_addr); // (RL13)

   // ------------------------------------------------------------
   // Read data register
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= DSF_STATUS_RESET;
      end else if (ce) begin
         if (rd_status) begin
            reg_rdata <= status; // (RL1)
         end else if (rd_other) begin
            reg_rdata <= 32'h0000_0000; // (RL13)
         end
      end
   end

   logic unused_wdata;
   assign unused_wdata = ^reg_wdata; // (RL13)
endmodule : dsf_driver_status

// File: verification/dsf_driver_status_props.sv
`timescale 1ns/1ps
module dsf_driver_status_props
   import dsf_pkg::*;
#(
   parameter int STST_CLOCKS = DSF_STST_CLOCKS
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic step_pulse,
   input wire logic [4:0] current_scale,
   input wire dsf_detect_s detect,
   input wire logic driver_on,
   input wire logic enable_input_low_active_n,
   input wire logic reg_rd,
   input wire logic [6:0] reg_addr,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_hit,
   input wire logic bridge_disable
);
   int idle;
   logic rd_st;
   assign rd_st = ce && reg_rd && reg_addr == DSF_DRIVER_STATUS_ADDR;
   always_ff @(posedge clk) begin
      if (srst || (ce && step_pulse)) begin
         idle <= 0;
      end else if (ce) begin
         idle <= idle + 1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   property p_hold; !(ce && reg_rd) |=> $stable(reg_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_hit; reg_rd |-> reg_hit == (reg_addr == DSF_DRIVER_STATUS_ADDR); endproperty
   a_hit: assert property (p_hit) else $error("bad hit");
   property p_rsvd; reg_rdata[30:21] == 10'h000 && reg_rdata[15:10] == 6'h00; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   property p_unmap; ce && reg_rd && !reg_hit |=> reg_rdata == 32'h0000_0000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_cs;
      rd_st && $past(ce) && !$past(srst) |=> reg_rdata[20:16] == $past(current_scale, 2);
   endproperty
   a_cs: assert property (p_cs) else $error("scale mismatch");
   property p_ot; ce && detect.overtemp_limit |=> bridge_disable; endproperty
   a_ot: assert property (p_ot) else $error("bridge on at overtemp");
   property p_temp_high_comparator; ce && detect.temp_high_comparator |=> bridge_disable; endproperty
   a_temp_high_comparator: assert property (p_temp_high_comparator) else $error("bridge on when hot");
   property p_clr;
      ce && (!driver_on || enable_input_low_active_n) && (detect & 9'h19F) == 9'h000
         |=> !bridge_disable;
   endproperty
   a_clr: assert property (p_clr) else $error("bridge off after clear");
   property p_stst; rd_st && idle > STST_CLOCKS + 1 |=> reg_rdata[31]; endproperty
   a_stst: assert property (p_stst) else $error("standstill missing");
   c_read: cover property (rd_st);
   c_short: cover property (bridge_disable && driver_on);
   c_stst: cover property (rd_st && idle > STST_CLOCKS + 1);
endmodule : dsf_driver_status_props
bind dsf_driver_status dsf_driver_status_props #(.STST_CLOCKS(STST_CLOCKS)) chk_u (
   .clk(clk), .srst(srst), .ce(ce), .step_pulse(step_pulse), .current_scale(current_scale),
   .detect(detect), .driver_on(driver_on), .enable_input_low_active_n(enable_input_low_active_n),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
   .bridge_disable(bridge_disable));

// File: verification/dsf_host_model.sv
`timescale 1ns/1ps
module dsf_host_model (
   input wire logic clk,
   input wire logic [31:0] reg_rdata,
   output logic reg_rd,
   output logic reg_wr,
   output logic [6:0] reg_addr,
   output logic [31:0] reg_wdata,
   output logic driver_on,
   output logic enable_input_low_active_n
);
   initial begin
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 32'h0000_0000;
      driver_on = 1'b1;
      enable_input_low_active_n = 1'b0;
   end
   task rd(input logic [6:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge clk);
      d = reg_rdata;
   endtask : rd
   task wr(input logic [6:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   task drive_en(input logic on, input logic en_n);
      @(posedge clk);
      driver_on <= on;
      enable_input_low_active_n <= en_n;
   endtask : drive_en
endmodule : dsf_host_model

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import dsf_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic step_pulse = 1'b1;
   logic [4:0] current_scale = 5'h15;
   logic chopper_mode = 1'b0;
   dsf_detect_s detect = '0;
   logic [31:0] reg_rdata, reg_wdata, got;
   logic reg_rd, reg_wr, driver_on, en_n, reg_hit, bridge_disable;
   logic [6:0] reg_addr;
   logic [9:0] exp_lo [9] = '{10'h200, 10'h101, 10'h080, 10'h040, 10'h020, 10'h010,
      10'h008, 10'h004, 10'h002};
   logic [8:0] bd_mask = 9'h11F;
   int num_errors = 0;
   int n_tests = 0;
   always #20 clk = ~clk;
   dsf_driver_status #(.STST_CLOCKS(16)) dut_u (.clk(clk), .srst(srst), .ce(ce),
      .step_pulse(step_pulse), .current_scale(current_scale), .chopper_mode(chopper_mode),
      .detect(detect), .driver_on(driver_on), .enable_input_low_active_n(en_n),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_hit(reg_hit), .bridge_disable(bridge_disable));
   dsf_host_model host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .driver_on(driver_on),
      .enable_input_low_active_n(en_n));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task wrap_up;
      $display("Errors %0d, checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      wrap_up;
   end
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      host_u.wr(DSF_DRIVER_STATUS_ADDR, 32'hFFFF_FFFF);
      host_u.rd(DSF_DRIVER_STATUS_ADDR, got);
      chk(got, 32'h0015_0000);
      host_u.rd(7'h6E, got);
      chk(got, 32'h0000_0000);
      for (int i = 0; i < 9; i++) begin
         @(posedge clk);
         detect <= dsf_detect_s'(9'h100 >> i);
         repeat (2) @(posedge clk);
         chk({31'h0, bridge_disable}, {31'h0, bd_mask[8-i]});
         host_u.rd(DSF_DRIVER_STATUS_ADDR, got);
         chk(got, {22'h000540, exp_lo[i]});
         detect <= '0;
         host_u.drive_en(1'b0, 1'b0);
         host_u.drive_en(1'b1, 1'b0);
      end
      @(posedge clk);
      detect <= 9'h010;
      @(posedge clk);
      detect <= '0;
      host_u.rd(DSF_DRIVER_STATUS_ADDR, got);
      chk(got, 32'h0015_0020);
      chopper_mode <= 1'b1;
      host_u.rd(DSF_DRIVER_STATUS_ADDR, got);
      chk(got, 32'h0015_0000);
      chopper_mode <= 1'b0;
      host_u.rd(DSF_DRIVER_STATUS_ADDR, got);
      chk(got, 32'h0015_0020);
      host_u.drive_en(1'b1, 1'b1);
      host_u.drive_en(1'b1, 1'b0);
      current_scale <= 5'h0A;
      host_u.rd(DSF_DRIVER_STATUS_ADDR, got);
      chk(got, 32'h000A_0000);
      step_pulse <= 1'b0;
      host_u.rd(DSF_DRIVER_STATUS_ADDR, got);
      chk(got, 32'h000A_0000);
      repeat (20) @(posedge clk);
      host_u.rd(DSF_DRIVER_STATUS_ADDR, got);
      chk(got, 32'h800A_0000);
      step_pulse <= 1'b1;
      host_u.rd(DSF_DRIVER_STATUS_ADDR, got);
      chk(got, 32'h000A_0000);
      ce <= 1'b0;
      detect <= 9'h081;
      repeat (3) @(posedge clk);
      chk({31'h0, bridge_disable}, 32'h0000_0000);
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      detect <= 9'h080;
      repeat (2) @(posedge clk);
      chk({31'h0, bridge_disable}, 32'h0000_0001);
      host_u.rd(DSF_DRIVER_STATUS_ADDR, got);
      chk(got, 32'h000A_0103);
      detect <= '0;
      repeat (2) @(posedge clk);
      chk({31'h0, bridge_disable}, 32'h0000_0000);
      chopper_mode <= 1'b1;
      detect <= 9'h002;
      @(posedge clk);
      detect <= '0;
      host_u.rd(DSF_DRIVER_STATUS_ADDR, got);
      chk(got, 32'h000A_0004);
      chopper_mode <= 1'b0;
      host_u.rd(DSF_DRIVER_STATUS_ADDR, got);
      chk(got, 32'h000A_0000);
      wrap_up;
   end
endmodule : tb_top
